//--- logic/hsq_regs.vh
// Purpose: constants for the homing sequencer
// Assumes: 20 MHz reference clock
// Notes:   definitions only
`ifndef HSQ_REGS_VH
`define HSQ_REGS_VH
// ==========================================================
// Timing
`define HSQ_CLK_NS        50
`define HSQ_MS_NS         1000000
`define HSQ_CYC_PER_MS    (`HSQ_MS_NS / `HSQ_CLK_NS)
`define HSQ_HOLD_DEF_MS   12'h064
`define HSQ_HOLD_MIN_MS   12'h001
// ==========================================================
// Trigger select codes
`define HSQ_TRIG_LEVEL    2'h1
`define HSQ_TRIG_EDGE     2'h2
`define HSQ_TRIG_AUTO     2'h3
// ==========================================================
// Method codes
`define HSQ_M_LIMNEG      6'h01
`define HSQ_M_LIMPOS      6'h02
`define HSQ_M_REF_LO      6'h03
`define HSQ_M_REF_HI      6'h0E
`define HSQ_M_LIMNEG_SW   6'h11
`define HSQ_M_LIMPOS_SW   6'h12
`define HSQ_M_SW_LO       6'h13
`define HSQ_M_SW_HI       6'h1E
`define HSQ_M_SW_SHIFT    6'h10
`define HSQ_M_IDX_NEG     6'h21
`define HSQ_M_IDX_POS     6'h22
`define HSQ_M_PRESET      6'h23
// ==========================================================
// Synchroniser bit positions
`define HSQ_SY_SERVO      0
`define HSQ_SY_REQ        1
`define HSQ_SY_LNEG       2
`define HSQ_SY_LPOS       3
`define HSQ_SY_HOME       4
`define HSQ_SY_INDEX      5
`define HSQ_SY_N          6
`endif

//--- logic/hsq_homing_sequencer.v
// Purpose: homing sequencer for a pulse-command servo drive
// Assumes: one 20 MHz clock; alarm comes from same-domain logic
// Notes:   direction 1 = positive; speeds pass through to the
//          profile generator, which applies accel/decel times
// Notes on behaviour
// - Level mode, servo on: request on starts homing, normal commands held.
// - Level mode done: clear position, done on until request goes off.
// - After any completion, hold at home, reject commands until done off.
// - Level mode: servo off, alarm or request drop aborts, no done.
// - Edge mode, servo on: request rising edge starts homing, commands held.
// - Edge mode done: clear position, done on for the hold time.
// - Edge mode: servo off, alarm or request fall aborts, no done.
// - Auto mode homes once at first servo enable after power-up.
// - Auto mode done: clear, done for hold time, then commands resume.
// - Auto mode aborts on servo off or alarm; never retriggers after.
// - Method 1: go negative, home at first index after limit releases.
// - Method 2: go positive, home at first index after limit releases.
// - Methods 3-6: direction from home switch, index after switch change.
// - Methods 7-10: direction by switch state, index near switch edge.
// - Methods 11-14: direction by switch state, negative limit reverses.
// - Methods 17,18: as 1,2 but home at limit release edge.
// - Methods 19-30: as 3-14 but home at switch change edge.
// - Methods 33,34: fixed direction, first index is home.
// - Method 35: no motion, present position becomes reference.
// - Fast speed searches reference, slow speed searches home; methods 17-30, 33, 34 home at fast speed.
// - Home offset is turns times 65536 plus pulses.
// - Done hold time 1 to 3000 ms, default 100 ms; only the low end is clamped, values up to 4095 ms pass unchanged.
`timescale 1ns/1ps
`include "hsq_regs.vh"

module hsq_homing_sequencer #(
  parameter CYC_PER_MS = `HSQ_CYC_PER_MS,
  parameter SPD_W      = 12
) (
  // Clock and reset
  input  wire              i_ref_clk,
  input  wire              i_arst_n,
  // Drive state
  input  wire              i_servo_enable_input,
  input  wire              i_alarm,
  // Pins, inputs mapped by the installer
  input  wire              i_homing_request_input,
  input  wire              i_limit_neg,
  input  wire              i_limit_pos,
  input  wire              i_home_switch,
  input  wire              i_index_pulse,
  // Configuration
  input  wire [1:0]        i_homing_trigger_select,
  input  wire [5:0]        i_homing_method_select,
  input  wire [11:0]       i_done_hold_time,
  input  wire [15:0]       i_offset_turns,
  input  wire [15:0]       i_offset_pulses,
  input  wire [SPD_W-1:0]  i_search_speed_fast,
  input  wire [SPD_W-1:0]  i_search_speed_slow,
  // Motion and status
  output reg               o_move_en,
  output reg               o_move_dir,
  output reg  [SPD_W-1:0]  o_move_speed,
  output reg               o_cmd_block,
  output reg               o_pos_clear,
  output reg  [31:0]       o_home_offset,
  output reg               o_homing_busy,
  output reg               o_homing_done
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_FAST = 4'h2;
  localparam [3:0] ST_SLOW = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ========================================================
  // Input synchronisers
  wire [`HSQ_SY_N-1:0] raw_in;
  reg  [`HSQ_SY_N-1:0] sy1_r;
  reg  [`HSQ_SY_N-1:0] sy2_r;
  reg  [`HSQ_SY_N-1:0] prev_r;

  assign raw_in = {i_index_pulse, i_home_switch, i_limit_pos,
                   i_limit_neg, i_homing_request_input,
                   i_servo_enable_input};

  genvar g;
  generate
    for (g = 0; g < `HSQ_SY_N; g = g + 1) begin : g_sync
      always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sy1_r[g]  <= 1'b0;
          sy2_r[g]  <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          sy1_r[g]  <= raw_in[g];
          sy2_r[g]  <= sy1_r[g];
          prev_r[g] <= sy2_r[g];
        end
      end
    end
  endgenerate

  wire servo   = sy2_r[`HSQ_SY_SERVO];
  wire req     = sy2_r[`HSQ_SY_REQ];
  wire lneg    = sy2_r[`HSQ_SY_LNEG];
  wire lpos    = sy2_r[`HSQ_SY_LPOS];
  wire homesw  = sy2_r[`HSQ_SY_HOME];
  wire [`HSQ_SY_N-1:0] rise = sy2_r & ~prev_r;
  wire [`HSQ_SY_N-1:0] fall = ~sy2_r & prev_r;
  wire servo_up = rise[`HSQ_SY_SERVO];
  wire req_up   = rise[`HSQ_SY_REQ];
  wire lneg_up  = rise[`HSQ_SY_LNEG];
  wire lneg_dn  = fall[`HSQ_SY_LNEG];
  wire lpos_up  = rise[`HSQ_SY_LPOS];
  wire lpos_dn  = fall[`HSQ_SY_LPOS];
  wire home_chg = rise[`HSQ_SY_HOME] | fall[`HSQ_SY_HOME];
  wire idx_up   = rise[`HSQ_SY_INDEX];

  // ========================================================
  // Method decode
  wire [5:0] meth = i_homing_method_select;
  wire sw_range = (meth >= `HSQ_M_SW_LO) && (meth <= `HSQ_M_SW_HI);
  wire [5:0] base = sw_range ? (meth - `HSQ_M_SW_SHIFT) : meth;
  wire edge_home = sw_range | (meth == `HSQ_M_LIMNEG_SW)
                 | (meth == `HSQ_M_LIMPOS_SW);
  wire m_lneg = (base == `HSQ_M_LIMNEG) | (meth == `HSQ_M_LIMNEG_SW);
  wire m_lpos = (base == `HSQ_M_LIMPOS) | (meth == `HSQ_M_LIMPOS_SW);
  wire m_ref  = (base >= `HSQ_M_REF_LO) && (base <= `HSQ_M_REF_HI);
  wire m_nlim = m_ref && (base >= 6'h0B);
  wire m_idx  = (meth == `HSQ_M_IDX_NEG) | (meth == `HSQ_M_IDX_POS);
  wire m_pre  = (meth == `HSQ_M_PRESET);
  wire m_ok   = m_lneg | m_lpos | m_ref | m_idx | m_pre;

  // Start direction per method
  reg start_dir;
  always @* begin
    start_dir = 1'b0;
    if (m_lneg) begin
      start_dir = lneg;
    end else if (m_lpos) begin
      start_dir = ~lpos;
    end else if (m_idx) begin
      start_dir = (meth == `HSQ_M_IDX_POS);
    end else begin
      case (base)
        6'h03, 6'h04: start_dir = ~homesw;
        6'h05, 6'h06: start_dir = homesw;
        6'h07, 6'h08: start_dir = ~homesw;
        6'h09, 6'h0A: start_dir = homesw;
        6'h0B, 6'h0C: start_dir = homesw;
        6'h0D, 6'h0E: start_dir = ~homesw;
        default:      start_dir = 1'b0;
      endcase
    end
  end

  // ========================================================
  // Trigger and abort
  wire t_level = (i_homing_trigger_select == `HSQ_TRIG_LEVEL);
  wire t_edge  = (i_homing_trigger_select == `HSQ_TRIG_EDGE);
  wire t_auto  = (i_homing_trigger_select == `HSQ_TRIG_AUTO);
  reg  auto_used_r;

  wire go = servo & ~i_alarm & (
              (t_level & req)
            | (t_edge & req_up)
            | (t_auto & servo_up & ~auto_used_r));

  // Early request drop only counts in request-driven modes
  wire abort = ~servo | i_alarm
             | (~t_auto & ~req);

  // Hold time clamped to its least legal value
  wire [11:0] hold_ms = (i_done_hold_time < `HSQ_HOLD_MIN_MS)
                      ? `HSQ_HOLD_MIN_MS : i_done_hold_time;

  // Offset in 65536-pulse turns plus pulses
  wire [31:0] offset_sum = {i_offset_turns, 16'h0000}
                         + {{16{i_offset_pulses[15]}},
                            i_offset_pulses};

  // ========================================================
  // Sequencer
  reg [3:0]  state_r;
  reg [31:0] tick_r;
  reg [11:0] ms_left_r;

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r       <= ST_IDLE;
      auto_used_r   <= 1'b0;
      tick_r        <= 32'h0000_0000;
      ms_left_r     <= 12'h000;
      o_move_en     <= 1'b0;
      o_move_dir    <= 1'b0;
      o_move_speed  <= {SPD_W{1'b0}};
      o_cmd_block   <= 1'b0;
      o_pos_clear   <= 1'b0;
      o_home_offset <= 32'h0000_0000;
      o_homing_busy <= 1'b0;
      o_homing_done <= 1'b0;
    end else begin
      o_pos_clear <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          o_move_en     <= 1'b0;
          o_homing_done <= 1'b0;
          o_cmd_block   <= 1'b0;
          // Auto mode spends its one chance on the first enable
          if (t_auto & servo_up) begin
            auto_used_r <= 1'b1;
          end
          if (go & m_ok) begin
            o_cmd_block   <= 1'b1;
            o_homing_busy <= 1'b1;
            if (m_pre) begin
              state_r       <= ST_DONE;
              o_homing_busy <= 1'b0;
              o_homing_done <= 1'b1;
              o_pos_clear   <= 1'b1;
              o_home_offset <= offset_sum;
              ms_left_r     <= hold_ms;
              tick_r        <= 32'h0000_0000;
            end else begin
              state_r      <= ST_FAST;
              o_move_en    <= 1'b1;
              o_move_dir   <= start_dir;
              o_move_speed <= i_search_speed_fast;
            end
          end
        end
        ST_FAST, ST_SLOW: begin
          if (abort) begin
            state_r       <= ST_IDLE;
            o_move_en     <= 1'b0;
            o_homing_busy <= 1'b0;
            o_cmd_block   <= 1'b0;
            o_homing_done <= 1'b0;
          end else if (state_r == ST_SLOW ? idx_up :
                       (m_idx ? idx_up :
                        (edge_home &
                         ((m_lneg & lneg_dn) | (m_lpos & lpos_dn)
                          | (m_ref & home_chg))))) begin
            state_r       <= ST_DONE;
            o_move_en     <= 1'b0;
            o_homing_busy <= 1'b0;
            o_homing_done <= 1'b1;
            o_pos_clear   <= 1'b1;
            o_home_offset <= offset_sum;
            ms_left_r     <= hold_ms;
            tick_r        <= 32'h0000_0000;
          end else if (state_r == ST_FAST) begin
            if ((m_lneg & lneg_up) | (m_nlim & lneg_up)) begin
              o_move_dir <= 1'b1;
            end else if (m_lpos & lpos_up) begin
              o_move_dir <= 1'b0;
            end else if ((m_lneg & lneg_dn) | (m_lpos & lpos_dn)) begin
              state_r      <= ST_SLOW;
              o_move_speed <= i_search_speed_slow;
            end else if (m_ref & home_chg) begin
              // Odd methods keep going, even ones turn back
              state_r      <= ST_SLOW;
              o_move_speed <= i_search_speed_slow;
              o_move_dir   <= base[0] ? o_move_dir : ~o_move_dir;
            end
          end
        end
        ST_DONE: begin
          // Motor sits at home; commands stay locked out
          o_cmd_block <= 1'b1;
          if (tick_r >= CYC_PER_MS - 1) begin
            tick_r <= 32'h0000_0000;
            if (ms_left_r != 12'h000) begin
              ms_left_r <= ms_left_r - 12'h001;
            end
          end else begin
            tick_r <= tick_r + 32'h0000_0001;
          end
          if (t_level ? ~req : (ms_left_r == 12'h000)) begin
            state_r       <= ST_IDLE;
            o_homing_done <= 1'b0;
            o_cmd_block   <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // hsq_homing_sequencer

//--- verif/hsq_motor_model.sv
// Purpose: motor, encoder and switch model for the homing bench
// Assumes: one step per four clocks; home switch band 20..40
// Notes:   limits beyond +/-60; index every 16 steps
`timescale 1ns/1ps
// ==========================================================
// Motor model
module hsq_motor_model (
  // Clock and preset
  input  wire       i_ref_clk,
  input  wire       i_set,
  input  wire [7:0] i_set_pos,
  // Motion request
  input  wire       i_move_en,
  input  wire       i_move_dir,
  // Switch and encoder pins
  output wire       o_limit_neg,
  output wire       o_limit_pos,
  output wire       o_home_switch,
  output wire       o_index_pulse
);
  integer   pos_r = 0;
  reg [1:0] div_r = 2'h0;
  // Slow stepping keeps each index pulse four clocks wide
  always @(posedge i_ref_clk) begin
    div_r <= div_r + 2'h1;
    if (i_set)
      pos_r <= $signed(i_set_pos);
    else if (i_move_en && div_r == 2'h3)
      pos_r <= i_move_dir ? pos_r + 1 : pos_r - 1;
  end
  // Pins wired to their assigned inputs
  assign o_limit_neg   = pos_r < -60;
  assign o_limit_pos   = pos_r > 60;
  assign o_home_switch = pos_r >= 20 && pos_r <= 40;
  assign o_index_pulse = pos_r % 16 == 0;
endmodule // hsq_motor_model

//--- verif/hsq_homing_sequencer_assertions.sv
// Purpose: port checks for the homing sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to the design top
`timescale 1ns/1ps
`include "hsq_regs.vh"
// ==========================================================
// Checker
module hsq_checker #(
  parameter CYC_PER_MS = `HSQ_CYC_PER_MS
) (
  // Clock, reset, inputs
  input wire        i_ref_clk,
  input wire        i_arst_n,
  input wire        i_servo_enable_input,
  input wire        i_alarm,
  input wire        i_homing_request_input,
  input wire [1:0]  i_homing_trigger_select,
  input wire [11:0] i_done_hold_time,
  input wire [15:0] i_offset_turns,
  input wire [15:0] i_offset_pulses,
  // Outputs
  input wire        o_move_en,
  input wire        o_cmd_block,
  input wire        o_pos_clear,
  input wire [31:0] o_home_offset,
  input wire        o_homing_busy,
  input wire        o_homing_done
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  wire        lvl = i_homing_trigger_select == `HSQ_TRIG_LEVEL;
  wire [31:0] hold_cyc = (i_done_hold_time == 12'h000 ? 32'h1 :
                          {20'h0, i_done_hold_time}) * CYC_PER_MS;
  wire [31:0] offs = {i_offset_turns, 16'h0000} +
                     {{16{i_offset_pulses[15]}}, i_offset_pulses};
  reg  [31:0] held_r;
  // Counter, since a long repetition would stall the tools
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      held_r <= 32'h0;
    else
      held_r <= o_homing_done ? held_r + 32'h1 : 32'h0;
  end
  // Servo pin low long enough to pass the synchroniser
  sequence servo_lost;
    !i_servo_enable_input [*3] ##0 o_homing_busy;
  endsequence
  sequence done_ends;
    $fell(o_homing_done) ##0 !lvl;
  endsequence
  done_with_clear_a: assert property
    ($rose(o_homing_done) |-> o_pos_clear) else $error("done no clear");
  clear_one_cycle_a: assert property
    (o_pos_clear |=> !o_pos_clear) else $error("clear too long");
  offset_value_a: assert property
    (o_pos_clear |-> o_home_offset == offs) else $error("bad offset");
  done_blocks_a: assert property
    (o_homing_done |-> o_cmd_block && !o_move_en) else $error("done free");
  run_blocks_a: assert property
    (o_homing_busy |-> o_cmd_block) else $error("run not blocking");
  alarm_abort_a: assert property
    (o_homing_busy && i_alarm |=> !o_homing_busy && !o_homing_done)
    else $error("alarm no abort");
  servo_abort_a: assert property
    (servo_lost |=> !o_homing_busy && !o_homing_done)
    else $error("servo off no abort");
  level_hold_a: assert property
    ((lvl && i_homing_request_input) [*3] ##0 o_homing_done |=>
     o_homing_done) else $error("done dropped early");
  level_release_a: assert property
    (lvl && o_homing_done && !i_homing_request_input |-> ##[1:4]
     !o_homing_done) else $error("done stuck");
  hold_time_a: assert property
    (done_ends |-> held_r >= hold_cyc && held_r <= hold_cyc + 32'h2)
    else $error("hold time wrong");
  release_frees_a: assert property
    ($fell(o_homing_done) |-> !o_cmd_block) else $error("still blocked");
endmodule // hsq_checker
bind hsq_homing_sequencer hsq_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .i_ref_clk, .i_arst_n, .i_servo_enable_input, .i_alarm,
  .i_homing_request_input, .i_homing_trigger_select, .i_done_hold_time,
  .i_offset_turns, .i_offset_pulses, .o_move_en, .o_cmd_block,
  .o_pos_clear, .o_home_offset, .o_homing_busy, .o_homing_done);

//--- verif/hsq_homing_sequencer_tb_top.sv
// Purpose: self-checking bench for the homing sequencer
// Assumes: CYC_PER_MS shortened to 10, hold of 2 ms
// Notes:   table of runs first, then aborts and auto mode
`timescale 1ns/1ps
`include "hsq_regs.vh"
`define CHK(nm, e, g) begin n_checks = n_checks + 1; \
  if ((g) !== (e)) begin num_errors = num_errors + 1; \
  $display("mismatch %s exp %0h seen %0h", nm, e, g); end end
`define WAITQ(c, n) begin k = 0; \
  while (!(c) && k < n) begin step(1); k = k + 1; end end
// ==========================================================
// Bench top
module hsq_homing_sequencer_tb_top;
  localparam HC = 20;
  reg         clk = 1'b0, rst_n = 1'b0, servo = 1'b0, alarm = 1'b0;
  reg         req = 1'b0, set = 1'b0;
  reg  [7:0]  set_pos = 8'h00;
  reg  [1:0]  trig = 2'h1;
  reg  [11:0] hold = 12'h002;
  reg  [5:0]  meth = 6'h01;
  wire        lneg, lpos, home, idx, en, dir, blk, clr, busy, done;
  wire [11:0] spd;
  wire [31:0] off;
  integer     num_errors = 0, n_checks = 0, cyc = 0, i, k;
  reg  [16:0] row;
  // Trigger, method, start position, first direction
  reg  [16:0] rows [0:13] = '{
    {2'h1,6'h01,8'h00,1'h0}, {2'h2,6'h02,8'h00,1'h1},
    {2'h1,6'h11,8'h00,1'h0}, {2'h2,6'h12,8'h00,1'h1},
    {2'h1,6'h07,8'h1E,1'h0}, {2'h2,6'h09,8'h1E,1'h1},
    {2'h1,6'h0B,8'h1E,1'h1}, {2'h2,6'h0D,8'h1E,1'h0},
    {2'h1,6'h17,8'h1E,1'h0}, {2'h2,6'h1D,8'h1E,1'h0},
    {2'h1,6'h13,8'h00,1'h1}, {2'h2,6'h21,8'h00,1'h0},
    {2'h1,6'h22,8'h00,1'h1}, {2'h1,6'h05,8'h32,1'h0}};
  hsq_homing_sequencer #(.CYC_PER_MS(10)) u_hsq_homing_sequencer (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_servo_enable_input(servo),
    .i_alarm(alarm), .i_homing_request_input(req), .i_limit_neg(lneg),
    .i_limit_pos(lpos), .i_home_switch(home), .i_index_pulse(idx),
    .i_homing_trigger_select(trig), .i_homing_method_select(meth),
    .i_done_hold_time(hold), .i_offset_turns(16'h0003),
    .i_offset_pulses(16'hFFF0), .i_search_speed_fast(12'h5A5),
    .i_search_speed_slow(12'h0A3), .o_move_en(en), .o_move_dir(dir),
    .o_move_speed(spd), .o_cmd_block(blk), .o_pos_clear(clr),
    .o_home_offset(off), .o_homing_busy(busy), .o_homing_done(done));
  hsq_motor_model u_hsq_motor_model (
    .i_ref_clk(clk), .i_set(set), .i_set_pos(set_pos), .i_move_en(en),
    .i_move_dir(dir), .o_limit_neg(lneg), .o_limit_pos(lpos),
    .o_home_switch(home), .o_index_pulse(idx));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  end
  task summarize;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task do_reset(input [1:0] t);
    begin
      rst_n = 1'b0; servo = 1'b0; trig = t; meth = 6'h01; set = 1'b1;
      set_pos = 8'h00;
      step(12);
      `CHK("reset", 1'b0, en | blk | busy | done | clr)
      rst_n = 1'b1; set = 1'b0;
      step(4);
    end
  endtask
  // Position is preset a cycle ahead so the switches are synced
  task start(input [5:0] m, input [7:0] p);
    begin
      meth = m; set = 1'b1; set_pos = p;
      step(1);
      set = 1'b0; req = 1'b1;
      `WAITQ(busy === 1'b1 || done === 1'b1, 10)
    end
  endtask
  initial begin
    do_reset(`HSQ_TRIG_LEVEL);
    servo = 1'b1;
    step(4);
    for (i = 0; i < 14; i = i + 1) begin
      row = rows[i];
      trig = row[16:15];
      start(row[14:9], row[8:1]);
      `CHK("dir", row[0], dir)
      `CHK("speed", 12'h5A5, spd)
      `CHK("block", 1'b1, blk & en)
      `WAITQ(done === 1'b1, 4000)
      `CHK("clear", 1'b1, clr)
      `CHK("slow", row[14:9] < 6'h0F ? 12'h0A3 : 12'h5A5, spd)
      `CHK("offset", 32'h0002FFF0, off)
      step(3);
      `CHK("hold", 1'b1, blk & done)
      if (trig == `HSQ_TRIG_LEVEL) begin
        step(30);
        `CHK("level", 1'b1, done)
        req = 1'b0;
        `WAITQ(done !== 1'b1, 8)
      end else begin
        `WAITQ(done !== 1'b1, 60)
        `CHK("time", 1'b1, k + 3 >= HC && k + 3 <= HC + 2)
        req = 1'b0;
      end
      `CHK("free", 1'b0, blk)
      step(4);
    end
    start(6'h01, 8'h00);
    alarm = 1'b1;
    step(1);
    `CHK("alarm", 1'b0, busy | done | en)
    alarm = 1'b0; req = 1'b0; trig = `HSQ_TRIG_EDGE;
    step(6);
    start(6'h02, 8'h00);
    req = 1'b0;
    step(4);
    `CHK("drop", 1'b0, busy | done)
    start(6'h02, 8'h00);
    servo = 1'b0;
    step(4);
    `CHK("servo", 1'b0, busy | done)
    servo = 1'b1; req = 1'b0; trig = `HSQ_TRIG_LEVEL;
    step(4);
    start(6'h0F, 8'h00);
    `CHK("invalid", 1'b0, busy | done)
    req = 1'b0;
    step(4);
    start(6'h23, 8'h00);
    `CHK("preset", 1'b1, done & clr & ~en)
    req = 1'b0;
    hold = 12'h000;
    do_reset(`HSQ_TRIG_AUTO);
    servo = 1'b1;
    `WAITQ(busy === 1'b1, 10)
    `CHK("auto", 1'b1, busy & en)
    `WAITQ(done === 1'b1, 4000)
    `WAITQ(done !== 1'b1, 60)
    `CHK("clamp", 1'b1, k >= 10 && k <= 12)
    `CHK("resume", 1'b0, blk)
    servo = 1'b0; step(4); servo = 1'b1; step(8);
    `CHK("once", 1'b0, busy | done)
    do_reset(`HSQ_TRIG_AUTO);
    servo = 1'b1;
    `WAITQ(busy === 1'b1, 10)
    alarm = 1'b1; step(1);
    `CHK("abort", 1'b0, busy | done)
    alarm = 1'b0; servo = 1'b0; step(4); servo = 1'b1; step(8);
    `CHK("retry", 1'b0, busy | done)
    summarize;
  end
endmodule // hsq_homing_sequencer_tb_top
